// ==== sim/tb_top.sv ====
`include "usart_async_regs.vh"
`default_nettype none
// bench: bus master tasks plus remote line partner
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, sys_rst, clkEn, sleepMode, psel, penable, pwrite, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0] gw;
  logic pready, pslverr, rxLine, txLine, txIrq, rxIrq;
  int miscompares = 0;
  int nTests = 0;
  usart_async #(.DIV_W(8)) i_usart_async (.mclk(mclk), .sys_rst(sys_rst),
    .clkEn(clkEn), .sleepMode(sleepMode), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxLine(rxLine), .txLine(txLine),
    .txIrq(txIrq), .rxIrq(rxIrq));
  uart_remote i_uart_remote (.mclk(mclk), .txLine(txLine), .rxLine(rxLine));
  // 100 MHz
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input string s, input logic [31:0] v, e);
    nTests++;
    if (v !== e)
    begin
      miscompares++;
      $display("[ERR] %s exp %h seen %h", s, e, v);
    end
  endtask
  // one transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1 && n++ < 50);
    if (pready !== 1'b1)
      miscompares++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // read helper: addr then expected
  task automatic rdc(input string s, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(s, rd, e);
  endtask
  // bounded wait for the receive request
  task automatic wait_rx;
    int n;
    n = 0;
    while (rxIrq !== 1'b1 && n++ < 400) @(posedge mclk);
  endtask
  task automatic t_regs;
    for (int i = 0; i < 8; i++)
      rdc("reset", 12'(i * 4), (i == 0) ? 32'h2 : 32'h0);
    apb(1'b1, `OFS_TXSTAT, 32'h0);
    rdc("shiftRo", `OFS_TXSTAT, 32'h2);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped", {rd[30:0], err}, 32'h1);
  endtask
  // two frames back to back; second waits for the first stop bit
  task automatic t_tx(input logic [7:0] dv, input logic hs, input logic nine);
    logic [9:0] g0, g1;
    int per;
    per = (hs ? 16 : 64) * (dv + 1);
    apb(1'b1, `OFS_BAUD, {24'h0, dv});
    apb(1'b1, `OFS_RXSTAT, 32'h80);
    apb(1'b1, `OFS_ENABLES, 32'h10);
    apb(1'b1, `OFS_TXSTAT, {25'h0, nine, 3'h4, hs, 1'b0, nine});
    apb(1'b1, `OFS_FLAGS, 32'h0);
    apb(1'b0, `OFS_FLAGS, 32'h0);
    chk("txEmpty", {rd[`PF_TX], txIrq}, 32'h3);
    fork
      begin
        apb(1'b1, `OFS_TXBUF, 32'hA5);
        apb(1'b1, `OFS_TXBUF, 32'h3C);
        apb(1'b0, `OFS_FLAGS, 32'h0);
        chk("txFull", rd[`PF_TX], 32'h0);
      end
      begin
        i_uart_remote.recv(8 + nine, per, g0);
        i_uart_remote.recv(8 + nine, per, g1);
      end
    join
    chk("frame0", g0, {nine, 1'b1, 8'hA5});
    chk("frame1", g1, {nine, 1'b1, 8'h3C});
    repeat (per) @(posedge mclk);
    apb(1'b0, `OFS_TXSTAT, 32'h0);
    chk("shiftEmpty", rd[`TX_SHEMPTY], 32'h1);
  endtask
  // receive, overrun, framing error, error clear
  task automatic t_rx;
    apb(1'b1, `OFS_ENABLES, 32'h20);
    apb(1'b1, `OFS_RXSTAT, 32'h90);
    i_uart_remote.send(9'h05A, 8, 16, 1'b1);
    wait_rx;
    chk("rxIrq", rxIrq, 32'h1);
    rdc("rxStat", `OFS_RXSTAT, 32'h90);
    rdc("rxData", `OFS_RXBUF, 32'h5A);
    apb(1'b0, `OFS_FLAGS, 32'h0);
    chk("rxClr", rd[`PF_RC], 32'h0);
    i_uart_remote.send(9'h011, 8, 16, 1'b1);
    i_uart_remote.send(9'h022, 8, 16, 1'b1);
    repeat (16) @(posedge mclk);
    rdc("overrun", `OFS_RXSTAT, 32'h92);
    rdc("kept", `OFS_RXBUF, 32'h11);
    apb(1'b1, `OFS_RXSTAT, 32'h80);
    apb(1'b1, `OFS_RXSTAT, 32'h90);
    i_uart_remote.send(9'h033, 8, 16, 1'b0);
    wait_rx;
    rdc("framing", `OFS_RXSTAT, 32'h94);
    apb(1'b1, `OFS_RXSTAT, 32'h80);
    rdc("errClr", `OFS_RXSTAT, 32'h80);
    apb(1'b0, `OFS_RXBUF, 32'h0);
  endtask
  // address detect keeps only ninth-bit-set frames
  task automatic t_addr;
    apb(1'b1, `OFS_RXSTAT, 32'hD8);
    i_uart_remote.send(9'h055, 9, 16, 1'b1);
    repeat (32) @(posedge mclk);
    chk("dropped", rxIrq, 32'h0);
    i_uart_remote.send(9'h1A7, 9, 16, 1'b1);
    wait_rx;
    rdc("addrStat", `OFS_RXSTAT, 32'hD9);
    rdc("addrData", `OFS_RXBUF, 32'hA7);
    apb(1'b1, `OFS_RXSTAT, 32'hD0);
    i_uart_remote.send(9'h033, 9, 16, 1'b1);
    wait_rx;
    rdc("allPass", `OFS_RXBUF, 32'h33);
  endtask
  task automatic conclude;
    if (miscompares == 0 && nTests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog against a hang
  initial
  begin
    repeat (30000) @(posedge mclk);
    miscompares++;
    conclude;
  end
  initial
  begin
    sys_rst = 1'b1;
    clkEn = 1'b1;
    sleepMode = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    t_regs;
    t_tx(8'h0, 1'b0, 1'b0);
    t_tx(8'h1, 1'b1, 1'b0);
    sleepMode <= 1'b1;
    apb(1'b1, `OFS_TXBUF, 32'h5A);
    repeat (80) @(posedge mclk);
    chk("sleepLine", txLine, 32'h1);
    sleepMode <= 1'b0;
    // frame held during sleep goes out on wake, at the last rate
    i_uart_remote.recv(8, 32, gw);
    chk("wakeFrame", gw, {2'b01, 8'h5A});
    repeat (32) @(posedge mclk);
    t_tx(8'h0, 1'b1, 1'b1);
    t_rx;
    t_addr;
    conclude;
  end
endmodule // tb_top
`default_nettype wire

// ==== sim/uart_remote.sv ====
`default_nettype none
// far end: drives the receive line, decodes the transmit line
module uart_remote (
  input wire logic mclk,
  input wire logic txLine,
  output logic rxLine
);
  timeunit 1ns;
  timeprecision 1ps;
  // mark level between frames
  initial rxLine = 1'b1;
  // start, nb data bits lsb first, stop of level sv
  task automatic send(input logic [8:0] d, input int nb, input int per,
    input logic sv);
    @(posedge mclk);
    for (int i = 0; i < nb + 2; i++)
    begin
      rxLine <= (i == 0) ? 1'b0 : (i > nb) ? sv : d[i - 1];
      repeat (per) @(posedge mclk);
    end
    rxLine <= 1'b1;
  endtask
  // bounded wait for a start edge, then sample mid-bit, stop bit last
  task automatic recv(input int nb, input int per, output logic [9:0] d);
    int n;
    d = 10'h0;
    n = 0;
    while (txLine !== 1'b0 && n++ < 5000) @(posedge mclk);
    repeat (per / 2) @(posedge mclk);
    for (int i = 0; i <= nb; i++)
    begin
      repeat (per) @(posedge mclk);
      d[i] = txLine;
    end
  endtask
endmodule // uart_remote
`default_nettype wire

// ==== sim/usart_async_checker.sv ====
`default_nettype none
// watches the bus answer, the serial line and the tx request
module usart_async_checker (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic sleepMode,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic txLine,
  input wire logic txIrq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // answer comes one cycle after the access is taken
  property p_answer; psel && penable && !pready && clkEn |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("late answer");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("long answer");
  property p_held; pready |-> psel && penable; endproperty
  a_held: assert property (p_held) else $error("stray answer");
  // registers are one byte wide
  property p_upper; pready |-> prdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper bits set");
  property p_unmap; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped data");
  // sleep must freeze the line
  property p_sleep; sleepMode && $past(sleepMode) |-> $stable(txLine); endproperty
  a_sleep: assert property (p_sleep) else $error("line moved");
  // no low run shorter than 8 cycles, half a fast bit
  property p_start; $fell(txLine) |-> !txLine [*8]; endproperty
  a_start: assert property (p_start) else $error("short bit");
  // reload happens only with the line at mark
  property p_reload; $rose(txIrq) |-> $past(txLine); endproperty
  a_reload: assert property (p_reload) else $error("mid-frame");
endmodule // usart_async_checker
bind usart_async usart_async_checker i_chk (.mclk(mclk), .sys_rst(sys_rst),
  .clkEn(clkEn), .sleepMode(sleepMode), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .txLine(txLine), .txIrq(txIrq));
`default_nettype wire

// ==== src/usart_async.v ====
`include "usart_async_regs.vh"
`default_nettype none
module usart_async #(
  parameter DIV_W = 8
) (
  input wire mclk,
  input wire sys_rst,
  input wire clkEn,
  input wire sleepMode,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire rxLine,
  output reg txLine,
  output reg txIrq,
  output reg rxIrq
);

  // registers visible to software, plus hidden txBuf9_r and txFull_r
  reg [7:0] txCtl_r; // transmit_status_control, shift-empty bit unused
  reg [7:0] rxCtl_r; // receive_status_control control bits
  reg [DIV_W-1:0] baudDiv_r; // baud_divisor
  reg [7:0] txBuf_r; // transmit_buffer
  reg txBuf9_r; // ninth bit latched with buffer
  reg txFull_r; // buffer holds unsent data
  reg txEmptyFlag_r; // transmit_buffer_empty_flag
  reg [7:0] rxBuf_r; // receive_buffer
  reg rxBuf9_r; // received_ninth_bit
  reg rxFlag_r; // receive_complete_flag
  reg framing_error_flag_r; // framing_error_flag
  reg overrun_error_flag_r; // overrun_error_flag
  reg [7:0] enables_r; // peripheral_enables_one
  reg [7:0] prio_r; // peripheral_priority_one, stored only

  // local register-bus decode, shared by read and write paths
  function hit;
    input [11:0] a;
    input [11:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  wire acc = psel & penable & ~pready; // one access cycle per transfer
  wire wrEn = acc & pwrite;
  wire rdEn = acc & ~pwrite;
  wire mapped = hit(paddr, `OFS_TXSTAT) | hit(paddr, `OFS_RXSTAT) |
    hit(paddr, `OFS_TXBUF) | hit(paddr, `OFS_RXBUF) |
    hit(paddr, `OFS_BAUD) | hit(paddr, `OFS_FLAGS) |
    hit(paddr, `OFS_ENABLES) | hit(paddr, `OFS_PRIO);

  // mode qualifiers
  wire asyncOn = rxCtl_r[`RX_PORTEN] & ~txCtl_r[`TX_SYNC];
  wire run = clkEn & ~sleepMode & asyncOn;
  wire txOn = run & txCtl_r[`TX_EN];
  wire rxOn = run & rxCtl_r[`RX_CONT];

  // baud generator, shared by both directions
  reg [DIV_W-1:0] brgCnt_r;
  reg [5:0] ovsCnt_r; // divides tick to bit rate for transmit
  wire divWrite = wrEn & hit(paddr, `OFS_BAUD);
  wire brgTick = run & (brgCnt_r == {DIV_W{1'b0}});
  // rx runs at x16 bit clock: in low-speed mode, x64 / 4
  reg [1:0] pre_r;
  wire rxTick = brgTick &
    (txCtl_r[`TX_HISPD] | (pre_r == 2'h3));
  wire [5:0] ovsTop = txCtl_r[`TX_HISPD] ? `OVS_HIGH : `OVS_LOW;
  wire bitTick = brgTick & (ovsCnt_r == ovsTop);

  // generator restart on divisor write
  always @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      brgCnt_r <= {DIV_W{1'b0}};
      ovsCnt_r <= 6'h00;
      pre_r <= 2'h0;
    end
    else if (clkEn)
    begin
      if (divWrite | ~run)
      begin
        // restart rather than wait for old period to expire
        brgCnt_r <= divWrite ? pwdata[DIV_W-1:0] : baudDiv_r;
        pre_r <= 2'h0;
      end
      else if (brgTick)
      begin
        brgCnt_r <= baudDiv_r; // period div+1
        pre_r <= pre_r + 2'h1;
      end
      else
        brgCnt_r <= brgCnt_r - {{(DIV_W-1){1'b0}}, 1'b1};
    end

  // transmitter: one-hot states
  localparam TX_IDLE = 2'b01;
  localparam TX_SEND = 2'b10;
  reg [1:0] txState_r;
  reg [10:0] tsr_r; // transmit_shift_register, never mapped
  reg [3:0] txBits_r; // bits left including stop
  wire txLoad = txOn & txFull_r & txState_r[0];
  wire txBufWrite = wrEn & hit(paddr, `OFS_TXBUF);
  wire txEnRise = wrEn & hit(paddr, `OFS_TXSTAT) &
    pwdata[`TX_EN] & ~txCtl_r[`TX_EN];

  // bit phase, restarted at each load so the start bit is whole
  always @(posedge mclk or posedge sys_rst)
    if (sys_rst)
      ovsCnt_r <= 6'h00;
    else if (clkEn)
    begin
      if (divWrite | ~run | txLoad | bitTick)
        ovsCnt_r <= 6'h00;
      else if (brgTick)
        ovsCnt_r <= ovsCnt_r + 6'h01;
    end

  always @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      txState_r <= TX_IDLE;
      tsr_r <= 11'h7FF;
      txBits_r <= 4'h0;
      txLine <= 1'b1;
    end
    else if (clkEn)
    begin
      case (txState_r)
        TX_IDLE:
        begin
          txLine <= 1'b1;
          if (txLoad)
          begin
            // stop, ninth (if any), data, start; shifted lsb first
            tsr_r <= txCtl_r[`TX_NINE] ?
              {1'b1, txBuf9_r, txBuf_r, 1'b0} :
              {2'b11, txBuf_r, 1'b0};
            txBits_r <= txCtl_r[`TX_NINE] ? `FRAME_BITS_9 : `FRAME_BITS_8;
            txState_r <= TX_SEND;
          end
        end
        TX_SEND:
        begin
          txLine <= tsr_r[0];
          if (~txCtl_r[`TX_EN])
            txState_r <= TX_IDLE; // abort on disable
          else if (bitTick)
          begin
            tsr_r <= {1'b1, tsr_r[10:1]};
            if (txBits_r == 4'h0)
              txState_r <= TX_IDLE; // stop bit done
            else
              txBits_r <= txBits_r - 4'h1;
          end
        end
        default:
          txState_r <= TX_IDLE;
      endcase
    end

  // receiver: oversampled recovery
  localparam RX_IDLE = 3'b001;
  localparam RX_START = 3'b010;
  localparam RX_DATA = 3'b100;
  reg [2:0] rxState_r;
  reg [3:0] phase_r; // x16 phase within a bit
  reg [2:0] votes_r; // three samples around mid-bit
  reg [9:0] rsr_r; // receive shifter
  reg [3:0] rxBits_r;
  reg rxDone_r; // one-cycle frame-complete strobe
  reg rxStop_r; // sampled stop level
  wire voteVal = (votes_r[0] & votes_r[1]) | (votes_r[0] & votes_r[2]) |
    (votes_r[1] & votes_r[2]);
  wire endOfBit = rxTick & (phase_r == `RX_TICKS);
  wire [3:0] rxLast = rxCtl_r[`RX_NINE] ? `FRAME_BITS_9 : `FRAME_BITS_8;

  always @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      rxState_r <= RX_IDLE;
      phase_r <= 4'h0;
      votes_r <= 3'h7;
      rsr_r <= 10'h000;
      rxBits_r <= 4'h0;
      rxDone_r <= 1'b0;
      rxStop_r <= 1'b1;
    end
    else if (clkEn)
    begin
      rxDone_r <= 1'b0;
      if (~rxOn)
        rxState_r <= RX_IDLE;
      else
      begin
        // gather samples at phases 6,7,8
        if (rxTick & (phase_r == `RX_VOTE_A | phase_r == `RX_MID |
            phase_r == `RX_VOTE_B))
          votes_r <= {votes_r[1:0], rxLine};
        if (rxTick)
          phase_r <= phase_r + 4'h1;
        case (rxState_r)
          RX_IDLE:
          begin
            phase_r <= 4'h0;
            if (~rxLine)
              rxState_r <= RX_START;
          end
          RX_START:
            if (endOfBit)
            begin
              // false start rejected by the vote
              rxState_r <= voteVal ? RX_IDLE : RX_DATA;
              rxBits_r <= 4'h1;
            end
          RX_DATA:
            if (endOfBit)
            begin
              if (rxBits_r == rxLast)
              begin
                rxStop_r <= voteVal;
                rxDone_r <= 1'b1;
                rxState_r <= RX_IDLE;
              end
              else
              begin
                // fill from top, lsb arrives first
                rsr_r <= rxCtl_r[`RX_NINE] ? {voteVal, rsr_r[9:1]} :
                  {1'b0, voteVal, rsr_r[8:1]};
                rxBits_r <= rxBits_r + 4'h1;
              end
            end
          default:
            rxState_r <= RX_IDLE;
        endcase
      end
    end

  // frame acceptance and address filtering
  wire adrMode = rxCtl_r[`RX_ADDR] & rxCtl_r[`RX_NINE];
  wire accept = rxDone_r & (~adrMode | rsr_r[9]);
  wire rxBufRead = rdEn & hit(paddr, `OFS_RXBUF);
  wire errClear = wrEn & hit(paddr, `OFS_RXSTAT) & ~pwdata[`RX_CONT];

  // software registers and hardware flags
  always @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      txCtl_r <= `TXSTAT_RST;
      rxCtl_r <= `ZERO8;
      baudDiv_r <= {DIV_W{1'b0}};
      txBuf_r <= `ZERO8;
      txBuf9_r <= 1'b0;
      txFull_r <= 1'b0;
      txEmptyFlag_r <= 1'b0;
      rxBuf_r <= `ZERO8;
      rxBuf9_r <= 1'b0;
      rxFlag_r <= 1'b0;
      framing_error_flag_r <= 1'b0;
      overrun_error_flag_r <= 1'b0;
      enables_r <= `ZERO8;
      prio_r <= `ZERO8;
    end
    else if (clkEn)
    begin
      if (wrEn & hit(paddr, `OFS_TXSTAT))
        txCtl_r <= pwdata[7:0];
      if (wrEn & hit(paddr, `OFS_RXSTAT))
        rxCtl_r <= pwdata[7:0];
      if (divWrite)
        baudDiv_r <= pwdata[DIV_W-1:0];
      if (wrEn & hit(paddr, `OFS_ENABLES))
        enables_r <= pwdata[7:0];
      if (wrEn & hit(paddr, `OFS_PRIO))
        prio_r <= pwdata[7:0];
      // buffer: write fills, load into shifter empties
      if (txBufWrite)
      begin
        txBuf_r <= pwdata[7:0];
        txBuf9_r <= txCtl_r[`TX_BIT9];
        txFull_r <= 1'b1;
      end
      else if (txLoad)
        txFull_r <= 1'b0;
      // empty flag: set wins, cleared only by a buffer write
      if (txLoad | txEnRise)
        txEmptyFlag_r <= 1'b1;
      else if (txBufWrite)
        txEmptyFlag_r <= 1'b0;
      // receive capture, unread data is kept on overrun
      if (accept & ~rxFlag_r)
      begin
        rxBuf_r <= rsr_r[8:1];
        rxBuf9_r <= rxCtl_r[`RX_NINE] & rsr_r[9];
        rxFlag_r <= 1'b1;
      end
      else if (rxBufRead)
        rxFlag_r <= 1'b0;
      // errors: event wins over clear
      if (accept & ~rxStop_r)
        framing_error_flag_r <= 1'b1;
      else if (errClear | (accept & rxStop_r & ~rxFlag_r))
        framing_error_flag_r <= 1'b0;
      if (accept & rxFlag_r & ~rxBufRead)
        overrun_error_flag_r <= 1'b1;
      else if (errClear)
        overrun_error_flag_r <= 1'b0;
    end

  // read mux
  reg [7:0] rdVal;
  always @*
  begin
    rdVal = `ZERO8;
    if (hit(paddr, `OFS_TXSTAT))
    begin
      rdVal = txCtl_r & 8'hF5; // bit 3 reserved
      rdVal[`TX_SHEMPTY] = txState_r[0];
    end
    else if (hit(paddr, `OFS_RXSTAT))
      rdVal = {rxCtl_r[7:3], framing_error_flag_r, overrun_error_flag_r, rxBuf9_r};
    else if (hit(paddr, `OFS_TXBUF))
      rdVal = txBuf_r;
    else if (hit(paddr, `OFS_RXBUF))
      rdVal = rxBuf_r;
    else if (hit(paddr, `OFS_BAUD))
      rdVal = baudDiv_r;
    else if (hit(paddr, `OFS_FLAGS))
    begin
      rdVal[`PF_RC] = rxFlag_r;
      rdVal[`PF_TX] = txEmptyFlag_r;
    end
    else if (hit(paddr, `OFS_ENABLES))
      rdVal = enables_r;
    else if (hit(paddr, `OFS_PRIO))
      rdVal = prio_r;
  end

  // apb answer: one wait state per access, registered outputs
  always @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      txIrq <= 1'b0;
      rxIrq <= 1'b0;
    end
    else if (clkEn)
    begin
      pready <= acc;
      pslverr <= acc & ~mapped;
      if (rdEn)
        prdata <= {24'h000000, rdVal};
      txIrq <= txEmptyFlag_r & enables_r[`PF_TX];
      rxIrq <= rxFlag_r & enables_r[`PF_RC];
    end

endmodule // usart_async
`default_nettype wire

// ==== src/usart_async_regs.vh ====
`ifndef USART_ASYNC_REGS_VH
`define USART_ASYNC_REGS_VH
// register byte addresses
`define OFS_TXSTAT 12'h000
`define OFS_RXSTAT 12'h004
`define OFS_TXBUF 12'h008
`define OFS_RXBUF 12'h00C
`define OFS_BAUD 12'h010
`define OFS_FLAGS 12'h014
`define OFS_ENABLES 12'h018
`define OFS_PRIO 12'h01C
// transmit_status_control fields
`define TX_CLKSRC 7
`define TX_NINE 6
`define TX_EN 5
`define TX_SYNC 4
`define TX_HISPD 2
`define TX_SHEMPTY 1
`define TX_BIT9 0
// receive_status_control fields
`define RX_PORTEN 7
`define RX_NINE 6
`define RX_SINGLE 5
`define RX_CONT 4
`define RX_ADDR 3
`define RX_FRAMING_ERROR_FLAG 2
`define RX_OVERRUN_ERROR_FLAG 1
`define RX_BIT9 0
// peripheral flag/enable positions
`define PF_RC 5
`define PF_TX 4
// reset values
`define TXSTAT_RST 8'h02
`define ZERO8 8'h00
// oversample figures
`define OVS_LOW 6'h3F
`define OVS_HIGH 6'h0F
`define RX_TICKS 4'hF
`define RX_MID 4'h7
`define RX_VOTE_A 4'h6
`define RX_VOTE_B 4'h8
`define FRAME_BITS_8 4'h9
`define FRAME_BITS_9 4'hA
`endif
